/* rtl/clock_output_config_pkg.sv */
// Constants for the clock output configuration register bank
package clock_output_config_pkg;

	// ==========================================================
	// Register offsets on the serial control port
	localparam logic [7:0] REG_DRIVE = 8'h05;
	localparam logic [7:0] REG_FORMAT = 8'h06;
	localparam logic [7:0] REG_MON_REF = 8'h07;
	localparam logic [7:0] REG_STATIC = 8'h08;
	localparam logic [7:0] REG_AVG = 8'h09;
	localparam logic [7:0] REG_POWERDOWN = 8'h0a;
	localparam int REG_COUNT = 6;

	// ==========================================================
	// Reset values, reserved bits included
	localparam logic [7:0] RST_DRIVE = 8'hed;
	localparam logic [7:0] RST_FORMAT = 8'h2d;
	localparam logic [7:0] RST_MON_REF = 8'h2a;
	localparam logic [7:0] RST_STATIC = 8'h00;
	localparam logic [7:0] RST_AVG = 8'hc0;
	localparam logic [7:0] RST_POWERDOWN = 8'h00;

	// ==========================================================
	// Writable bit masks; other bits are read-only
	localparam logic [7:0] WM_DRIVE = 8'hc0;
	localparam logic [7:0] WM_FORMAT = 8'h3f;
	localparam logic [7:0] WM_MON_REF = 8'h07;
	localparam logic [7:0] WM_STATIC = 8'hf0;
	localparam logic [7:0] WM_AVG = 8'hf8;
	localparam logic [7:0] WM_POWERDOWN = 8'h0c;

	// ==========================================================
	// Field positions
	localparam int DRIVE_LSB = 6;
	localparam int FMT_B_LSB = 3;
	localparam int FMT_A_LSB = 0;
	localparam int MON_REF_LSB = 0;
	localparam int LVL_B_LSB = 6;
	localparam int LVL_A_LSB = 4;
	localparam int AVG_LSB = 3;
	localparam int PD_B_BIT = 3;
	localparam int PD_A_BIT = 2;

	// ==========================================================
	// Output format codes
	localparam logic [2:0] FMT_DISABLE = 3'h1;
	localparam logic [2:0] FMT_CMOS = 3'h2;
	localparam logic [2:0] FMT_LVDS_LOW = 3'h3;
	localparam logic [2:0] FMT_LVPECL = 3'h5;
	localparam logic [2:0] FMT_CML = 3'h6;
	localparam logic [2:0] FMT_LVDS = 3'h7;

	// Monitoring reference codes
	localparam logic [2:0] MREF_EXT = 3'h0;
	localparam logic [2:0] MREF_IN_A = 3'h1;
	localparam logic [2:0] MREF_IN_B = 3'h2;

	// Static level codes
	localparam logic [1:0] LVL_NORMAL = 2'h0;
	localparam logic [1:0] LVL_LOW = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// Glitch-free gate states
	typedef enum logic {
		ST_FOLLOW = 1'b0,
		ST_HOLD = 1'b1
	} gate_state_e;

endpackage : clock_output_config_pkg

/* rtl/static_level_gate.sv */
// Glitch-free gate that forces one clock output to a static level
`timescale 1ns/1ps
module static_level_gate (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic src_clock_i,
	input wire logic [1:0] level_sel_i,
	output logic gated_o,
	output logic holding_o
);
	import clock_output_config_pkg::*;

	gate_state_e state;
	logic held;
	logic want_hold;
	logic target;

	// Requested level; reserved code keeps the present state
	assign want_hold = (level_sel_i == LVL_LOW) || (level_sel_i == LVL_HIGH);
	assign target = (level_sel_i == LVL_HIGH);

	// Switch only where the source already sits at the level we go to
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_FOLLOW;
			held <= 1'b0;
			gated_o <= 1'b0;
		end else if (enable_i) begin
			case (state)
				ST_FOLLOW: begin
					gated_o <= src_clock_i;
					if (want_hold && src_clock_i == target) begin
						state <= ST_HOLD;
						held <= target;
					end
				end
				ST_HOLD: begin
					gated_o <= held;
					if (level_sel_i == LVL_NORMAL && src_clock_i == held) begin
						state <= ST_FOLLOW;
					end else if (want_hold && target != held && src_clock_i == target) begin
						held <= target;
					end
				end
				default: begin
					state <= ST_FOLLOW;
				end
			endcase
		end
	end

	assign holding_o = (state == ST_HOLD);

	// Output changes only when it takes the value the source or the held level showed
	property p_no_runt;
		@(posedge clock_i) disable iff (!reset_n_i)
		$changed(gated_o) |-> gated_o == $past(src_clock_i) || gated_o == $past(held);
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("static gate glitch");

	// A held output stays still while the gate keeps holding the same level
	sequence s_holding;
		enable_i && state == ST_HOLD ##1 state == ST_HOLD && $stable(held);
	endsequence
	property p_hold_static;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_holding |=> $stable(gated_o);
	endproperty
	a_hold_static: assert property (p_hold_static) else $error("held output moved");

endmodule : static_level_gate

/* rtl/clock_output_config_regs.sv */
// Configuration register bank for the two clock outputs of one loop
`timescale 1ns/1ps
module clock_output_config_regs (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic out_a_divider_clk_i,
	input wire logic out_b_divider_clk_i,
	input wire logic bypass_req_i,
	input wire logic [4:0] history_delay_i,
	input wire logic force_hold_i,
	input wire logic auto_hold_i,
	output logic clock_out_a_o,
	output logic clock_out_b_o,
	output logic out_a_buffer_en_o,
	output logic out_b_buffer_en_o,
	output logic out_a_divider_en_o,
	output logic out_b_divider_en_o,
	output logic [2:0] out_a_format_o,
	output logic [2:0] out_b_format_o,
	output logic [1:0] drive_current_sel_o,
	output logic out_a_bypass_o,
	output logic out_b_bypass_o,
	output logic [2:0] offset_monitor_ref_o,
	output logic [4:0] history_avg_time_o,
	output logic [4:0] history_delay_o,
	output logic hold_mode_o
);
	import clock_output_config_pkg::*;

	// ==========================================================
	// Register storage
	localparam logic [7:0] RST_VAL [0:REG_COUNT-1] = '{RST_DRIVE, RST_FORMAT, RST_MON_REF,
		RST_STATIC, RST_AVG, RST_POWERDOWN};
	localparam logic [7:0] WR_MASK [0:REG_COUNT-1] = '{WM_DRIVE, WM_FORMAT, WM_MON_REF,
		WM_STATIC, WM_AVG, WM_POWERDOWN};

	logic [7:0] regs [0:REG_COUNT-1];
	logic hit;
	logic [2:0] idx;
	logic [7:0] offset;
	logic [2:0] fmt_a;
	logic [2:0] fmt_b;
	logic [1:0] lvl_a;
	logic [1:0] lvl_b;
	logic pd_a;
	logic pd_b;
	logic [2:0] mref;
	logic gate_a;
	logic gate_b;

	// Address decode; anything outside the bank reads zero
	assign offset = reg_addr_i - REG_DRIVE;
	assign hit = (reg_addr_i >= REG_DRIVE) && (reg_addr_i <= REG_POWERDOWN);
	assign idx = offset[2:0];

	// Writes touch only writable bits; read-only bits keep reset values
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= RST_VAL[i];
			end
		end else if (enable_i && reg_wr_i && hit) begin
			regs[idx] <= (reg_wdata_i & WR_MASK[idx]) | (RST_VAL[idx] & ~WR_MASK[idx]);
		end
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (enable_i && reg_rd_i) begin
			reg_rdata_o <= hit ? regs[idx] : 8'h00;
		end
	end

	// ==========================================================
	// Field extraction
	assign fmt_b = regs[1][FMT_B_LSB +: 3];
	assign fmt_a = regs[1][FMT_A_LSB +: 3];
	assign mref = regs[2][MON_REF_LSB +: 3];
	assign lvl_b = regs[3][LVL_B_LSB +: 2];
	assign lvl_a = regs[3][LVL_A_LSB +: 2];
	assign pd_b = regs[5][PD_B_BIT];
	assign pd_a = regs[5][PD_A_BIT];

	// Buffer runs on a valid non-disable format and no powerdown
	function automatic logic fmt_live(input logic [2:0] f);
		fmt_live = (f == FMT_CMOS) || (f == FMT_LVDS_LOW) || (f == FMT_LVPECL) ||
			(f == FMT_CML) || (f == FMT_LVDS);
	endfunction : fmt_live

	// Buffer, divider and format controls
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_a_buffer_en_o <= 1'b0;
			out_b_buffer_en_o <= 1'b0;
			out_a_divider_en_o <= 1'b0;
			out_b_divider_en_o <= 1'b0;
			out_a_format_o <= FMT_DISABLE;
			out_b_format_o <= FMT_DISABLE;
		end else if (enable_i) begin
			out_b_format_o <= fmt_b;
			out_a_format_o <= fmt_a;
			out_b_buffer_en_o <= fmt_live(fmt_b) && !pd_b;
			out_a_buffer_en_o <= fmt_live(fmt_a) && !pd_a;
			out_b_divider_en_o <= !pd_b;
			out_a_divider_en_o <= !pd_a;
		end
	end

	// Drive strength applies in CMOS mode; bypass is barred there
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_current_sel_o <= 2'h0;
			out_a_bypass_o <= 1'b0;
			out_b_bypass_o <= 1'b0;
		end else if (enable_i) begin
			drive_current_sel_o <= regs[0][DRIVE_LSB +: 2];
			out_a_bypass_o <= bypass_req_i && fmt_a != FMT_CMOS;
			out_b_bypass_o <= bypass_req_i && fmt_b != FMT_CMOS;
		end
	end

	// Monitor reference; reserved codes fall back to the external reference
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			offset_monitor_ref_o <= MREF_EXT;
		end else if (enable_i) begin
			offset_monitor_ref_o <= (mref == MREF_IN_A || mref == MREF_IN_B) ? mref : MREF_EXT;
		end
	end

	// Digital hold history settings and forced hold
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			history_avg_time_o <= 5'h00;
			history_delay_o <= 5'h00;
			hold_mode_o <= 1'b0;
		end else if (enable_i) begin
			history_avg_time_o <= regs[4][AVG_LSB +: 5];
			history_delay_o <= history_delay_i;
			hold_mode_o <= force_hold_i || auto_hold_i;
		end
	end

	// ==========================================================
	// Glitch-free static level gates, one per output
	static_level_gate u_gate_a (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.enable_i(enable_i),
		.src_clock_i(out_a_divider_clk_i),
		.level_sel_i(lvl_a),
		.gated_o(gate_a),
		.holding_o()
	);

	static_level_gate u_gate_b (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.enable_i(enable_i),
		.src_clock_i(out_b_divider_clk_i),
		.level_sel_i(lvl_b),
		.gated_o(gate_b),
		.holding_o()
	);

	// Output clocks; a powered-down output sits low
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clock_out_a_o <= 1'b0;
			clock_out_b_o <= 1'b0;
		end else if (enable_i) begin
			clock_out_a_o <= gate_a && !pd_a;
			clock_out_b_o <= gate_b && !pd_b;
		end
	end

	// ==========================================================
	// Checks
	property p_drive;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i |=> drive_current_sel_o == $past(regs[0][7:6]);
	endproperty
	a_drive: assert property (p_drive) else $error("drive select mismatch");

	property p_fmt_b;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && fmt_b == FMT_DISABLE |=> !out_b_buffer_en_o;
	endproperty
	a_fmt_b: assert property (p_fmt_b) else $error("output B on while disabled");

	property p_fmt_a;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && !pd_a && (fmt_a == FMT_CML || fmt_a == FMT_CMOS) |=> out_a_buffer_en_o;
	endproperty
	a_fmt_a: assert property (p_fmt_a) else $error("output A not enabled");

	property p_no_bypass;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && (fmt_a == FMT_CMOS || fmt_b == FMT_CMOS)
			|=> !(out_a_bypass_o && out_a_format_o == FMT_CMOS) && !(out_b_bypass_o && out_b_format_o == FMT_CMOS);
	endproperty
	a_no_bypass: assert property (p_no_bypass) else $error("bypass in CMOS mode");

	property p_mref;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && mref == MREF_IN_B |=> offset_monitor_ref_o == MREF_IN_B;
	endproperty
	a_mref: assert property (p_mref) else $error("monitor reference wrong");

	// Three enabled cycles cover a pending switch away from a held opposite level
	sequence s_hold_b_low;
		enable_i && lvl_b == LVL_LOW && !out_b_divider_clk_i ##1 enable_i && lvl_b == LVL_LOW
			##1 enable_i && lvl_b == LVL_LOW;
	endsequence
	property p_static_b;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_hold_b_low |=> !clock_out_b_o;
	endproperty
	a_static_b: assert property (p_static_b) else $error("output B not held low");

	sequence s_hold_a_high;
		enable_i && lvl_a == LVL_HIGH && out_a_divider_clk_i && !pd_a ##1 enable_i && lvl_a == LVL_HIGH && !pd_a
			##1 enable_i && lvl_a == LVL_HIGH && !pd_a;
	endsequence
	property p_static_a;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_hold_a_high |=> clock_out_a_o;
	endproperty
	a_static_a: assert property (p_static_a) else $error("output A not held high");

	property p_avg;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i |=> history_avg_time_o == $past(regs[4][7:3]);
	endproperty
	a_avg: assert property (p_avg) else $error("averaging time mismatch");

	property p_pd;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && pd_b && pd_a |=> !out_b_divider_en_o && !out_a_divider_en_o && !clock_out_b_o && !clock_out_a_o;
	endproperty
	a_pd: assert property (p_pd) else $error("powered-down output active");

	property p_pd_a;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && !pd_a |=> out_a_divider_en_o;
	endproperty
	a_pd_a: assert property (p_pd_a) else $error("divider A not enabled");

	property p_delay;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i |=> history_delay_o == $past(history_delay_i);
	endproperty
	a_delay: assert property (p_delay) else $error("history delay mismatch");

	property p_force;
		@(posedge clock_i) disable iff (!reset_n_i)
		enable_i && force_hold_i |=> hold_mode_o;
	endproperty
	a_force: assert property (p_force) else $error("forced hold ignored");

endmodule : clock_output_config_regs

/* verification/tb_top.sv */
// Self-checking testbench for the clock output configuration register bank
`timescale 1ns/1ps
module tb_top;
	import clock_output_config_pkg::*;
	localparam logic [7:0] OFFS [6] = '{REG_DRIVE, REG_FORMAT, REG_MON_REF, REG_STATIC, REG_AVG, REG_POWERDOWN};
	localparam logic [7:0] RSTS [6] = '{RST_DRIVE, RST_FORMAT, RST_MON_REF, RST_STATIC, RST_AVG, RST_POWERDOWN};
	localparam logic [7:0] WMS [6] = '{WM_DRIVE, WM_FORMAT, WM_MON_REF, WM_STATIC, WM_AVG, WM_POWERDOWN};
	localparam bit LOW_SUPPLY = 1'b0; // Bench models the 2.5 V supply
	// ==========================================================
	// Stimulus and observed signals
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic enable_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_rd_i = 1'b0;
	logic [1:0] div_cnt = 2'h0;
	logic bypass_req_i = 1'b0;
	logic [4:0] history_delay_i = 5'h00;
	logic force_hold_i = 1'b0;
	logic auto_hold_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic clock_out_a_o, clock_out_b_o, out_a_buffer_en_o, out_b_buffer_en_o;
	logic out_a_divider_en_o, out_b_divider_en_o, out_a_bypass_o, out_b_bypass_o, hold_mode_o;
	logic [2:0] out_a_format_o, out_b_format_o, offset_monitor_ref_o;
	logic [1:0] drive_current_sel_o;
	logic [4:0] history_avg_time_o, history_delay_o;
	logic [7:0] model [6];
	logic [15:0] lf = 16'h4da8; // Seed 19880
	logic watch = 1'b0;
	logic last_b = 1'b0;
	logic prev_a = 1'b0;
	int run_b = 2;
	int bad_count = 0;
	int n_compared = 0;

	clock_output_config_regs i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .out_a_divider_clk_i(div_cnt[0]), .out_b_divider_clk_i(div_cnt[1]),
		.bypass_req_i(bypass_req_i), .history_delay_i(history_delay_i), .force_hold_i(force_hold_i),
		.auto_hold_i(auto_hold_i), .clock_out_a_o(clock_out_a_o), .clock_out_b_o(clock_out_b_o),
		.out_a_buffer_en_o(out_a_buffer_en_o), .out_b_buffer_en_o(out_b_buffer_en_o),
		.out_a_divider_en_o(out_a_divider_en_o), .out_b_divider_en_o(out_b_divider_en_o),
		.out_a_format_o(out_a_format_o), .out_b_format_o(out_b_format_o),
		.drive_current_sel_o(drive_current_sel_o), .out_a_bypass_o(out_a_bypass_o),
		.out_b_bypass_o(out_b_bypass_o), .offset_monitor_ref_o(offset_monitor_ref_o),
		.history_avg_time_o(history_avg_time_o), .history_delay_o(history_delay_o), .hold_mode_o(hold_mode_o));

	// ==========================================================
	// Clock, divider levels and timeout
	initial begin
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		div_cnt <= #1 div_cnt + 2'h1;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		bad_count++;
		tally_and_finish();
	end
	// Output B runs shorter than two cycles are runt pulses
	always @(posedge clock_i) begin
		if (clock_out_b_o !== last_b) begin
			if (watch && run_b < 2) chk(8'(run_b), 8'h02);
			run_b <= 1;
			last_b <= clock_out_b_o;
		end else begin
			run_b <= run_b + 1;
		end
	end

	// ==========================================================
	// Shared tasks and expectation functions
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clock_i);
		#1;
	endtask : step
	task automatic wrm(input int i, input logic [7:0] w);
		reg_addr_i = OFFS[i];
		reg_wdata_i = w;
		reg_wr_i = 1'b1;
		step();
		reg_wr_i = 1'b0;
		model[i] = (RSTS[i] & ~WMS[i]) | (w & WMS[i]);
		step();
	endtask : wrm
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		step();
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
		step();
	endtask : rd
	task automatic read_all();
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			rd(OFFS[i], v);
			chk(v, model[i]);
		end
		rd(8'h0b, v);
		chk(v, 8'h00);
	endtask : read_all
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic fmt_on(input logic [2:0] f);
		return f inside {FMT_CMOS, FMT_LVDS_LOW, FMT_LVPECL, FMT_CML, FMT_LVDS};
	endfunction : fmt_on
	// Keeps random writes free of reserved codes
	function automatic logic [7:0] legal(input int i, input logic [7:0] w);
		logic [7:0] r;
		r = w;
		if (i == 1 && r[1:0] == 2'b00) r[0] = 1'b1;
		if (i == 1 && r[4:3] == 2'b00) r[3] = 1'b1;
		if (LOW_SUPPLY && i == 1 && r[2:0] == FMT_LVPECL) r[2:0] = FMT_LVDS;
		if (LOW_SUPPLY && i == 1 && r[5:3] == FMT_LVPECL) r[5:3] = FMT_LVDS;
		if (i == 2 && r[2:0] > 3'h2) r[2:0] = 3'h0;
		if (i == 3 && r[7:6] == 2'b11) r[7:6] = 2'b00;
		if (i == 3 && r[5:4] == 2'b11) r[5:4] = 2'b00;
		return r;
	endfunction : legal
	task automatic check_outs();
		logic [2:0] fa;
		logic [2:0] fb;
		fa = model[1][2:0];
		fb = model[1][5:3];
		chk(8'(drive_current_sel_o), 8'(model[0][7:6]));
		chk(8'(out_a_format_o), 8'(fa));
		chk(8'(out_b_format_o), 8'(fb));
		chk(8'(out_a_buffer_en_o), 8'(fmt_on(fa) && !model[5][2]));
		chk(8'(out_b_buffer_en_o), 8'(fmt_on(fb) && !model[5][3]));
		chk(8'(out_a_divider_en_o), 8'(!model[5][2]));
		chk(8'(out_b_divider_en_o), 8'(!model[5][3]));
		chk(8'(out_a_bypass_o), 8'(bypass_req_i && fa != FMT_CMOS));
		chk(8'(out_b_bypass_o), 8'(bypass_req_i && fb != FMT_CMOS));
		chk(8'(offset_monitor_ref_o), 8'(model[2][2:0]));
		chk(8'(history_avg_time_o), 8'(model[4][7:3]));
		chk(8'(history_delay_o), 8'(history_delay_i));
		chk(8'(hold_mode_o), 8'(force_hold_i || auto_hold_i));
	endtask : check_outs
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Main sequence
	initial begin
		model = RSTS;
		repeat (4) @(posedge clock_i);
		#1;
		reset_n_i = 1'b1;
		step();
		step();
		check_outs();
		reg_addr_i = 8'h04;
		reg_wdata_i = 8'hff;
		reg_wr_i = 1'b1;
		step();
		reg_addr_i = 8'h0b;
		step();
		reg_wr_i = 1'b0;
		read_all();
		$display("test reset values done");
		// Every format and monitor code, bypass requested
		bypass_req_i = 1'b1;
		for (int k = 0; k < 8; k++) begin
			if (k != 0 && k != 4 && !(LOW_SUPPLY && k == 5)) begin
				wrm(1, {2'b00, 3'(k), 3'(k)});
				wrm(2, 8'(k % 3));
				step();
				check_outs();
			end
		end
		$display("test format codes done");
		for (int n = 0; n < 60; n++) begin
			lf = lfsr_next(lf);
			bypass_req_i = lf[9];
			force_hold_i = lf[10];
			auto_hold_i = lf[11];
			history_delay_i = lf[15:11];
			wrm(int'(lf[14:8]) % 6, legal(int'(lf[14:8]) % 6, lf[7:0]));
			step();
			check_outs();
		end
		read_all();
		$display("test random writes done");
		// Static levels, then back to following the divider
		wrm(5, 8'h00);
		watch = 1'b1;
		for (int k = 0; k < 2; k++) begin
			wrm(3, k ? 8'h90 : 8'h60);
			repeat (8) step();
			repeat (8) begin
				chk(8'(clock_out_b_o), 8'(k));
				chk(8'(clock_out_a_o), 8'(!k));
				step();
			end
		end
		wrm(3, 8'h00);
		repeat (8) step();
		repeat (8) begin
			prev_a = clock_out_a_o;
			step();
			chk(8'(clock_out_a_o), 8'(!prev_a));
		end
		watch = 1'b0;
		// Clock enable low freezes all state and drops the pending write
		enable_i = 1'b0;
		reg_addr_i = REG_DRIVE;
		reg_wdata_i = ~model[0];
		reg_wr_i = 1'b1;
		prev_a = clock_out_a_o;
		repeat (4) begin
			step();
			chk(8'(clock_out_a_o), 8'(prev_a));
		end
		reg_wr_i = 1'b0;
		enable_i = 1'b1;
		repeat (3) step();
		chk(8'(drive_current_sel_o), 8'(model[0][7:6]));
		$display("test static levels done");
		wrm(5, 8'h0c);
		repeat (4) step();
		repeat (8) begin
			chk({6'h00, clock_out_b_o, clock_out_a_o}, 8'h00);
			step();
		end
		check_outs();
		$display("test powerdown done");
		reset_n_i = 1'b0;
		step();
		reset_n_i = 1'b1;
		model = RSTS;
		step();
		step();
		check_outs();
		read_all();
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : tb_top
